/* File: hdl/rfc_mem.sv */
`timescale 1ns/1ps
module rfc_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          CLK,
  input  wire logic          WE,
  input  wire logic [AW-1:0] WADDR,
  input  wire logic [DW-1:0] WDATA,
  input  wire logic          RE,
  input  wire logic [AW-1:0] RADDR,
  output logic      [DW-1:0] RDATA
);

  logic [DW-1:0] mem_ff [0:(1<<AW)-1];
  logic [DW-1:0] rdata_ff;

  always_ff @(posedge CLK) begin
    if (WE) begin
      mem_ff[WADDR] <= WDATA;
    end
    if (RE) begin
      rdata_ff <= mem_ff[RADDR];
    end
  end

  assign RDATA = rdata_ff;

endmodule : rfc_mem

/* File: hdl/rfc_pkg.sv */
package rfc_pkg;

  // register byte addresses
  localparam logic [7:0]  RFC_CTRL_OFS  = 8'h74;
  localparam logic [7:0]  RFC_STAT_OFS  = 8'h80;
  localparam logic [7:0]  RFC_CNT_OFS   = 8'h84;
  localparam logic [15:0] RFC_CTRL_RST  = 16'h0000;

  // receive control field positions
  localparam int RFC_B_FLUSH   = 15;
  localparam int RFC_B_UDP     = 14;
  localparam int RFC_B_TCP     = 13;
  localparam int RFC_B_IP      = 12;
  localparam int RFC_B_UFILT   = 11;
  localparam int RFC_B_PAUSE   = 10;
  localparam int RFC_B_CRCKEEP = 9;
  localparam int RFC_B_MFILT   = 8;
  localparam int RFC_B_BCAST   = 7;
  localparam int RFC_B_MCAST   = 6;
  localparam int RFC_B_UCAST   = 5;
  localparam int RFC_B_PROM    = 4;
  localparam int RFC_B_INV     = 1;
  localparam int RFC_B_RUN     = 0;

  // status field positions
  localparam int RFC_S_RUN     = 0;
  localparam int RFC_S_BUSY    = 1;
  localparam int RFC_S_FLUSHED = 2;
  localparam int RFC_S_PAUSED  = 3;

  // pause quantum is 512 bit times at 100 Mb/s
  localparam int RFC_CLK_NS      = 4;
  localparam int RFC_QUANTUM_NS  = 5120;
  localparam int RFC_QUANTUM_CYC = (RFC_QUANTUM_NS + RFC_CLK_NS - 1)
                                   / RFC_CLK_NS;

  // destination address layout, first byte in [47:40]
  localparam logic [2:0]  RFC_DA_BYTES  = 3'h6;
  localparam logic [47:0] RFC_BCAST_DA  = 48'hffff_ffff_ffff;
  localparam int          RFC_MCAST_BIT = 40;

  typedef enum logic [1:0] {
    RFC_IDLE,
    RFC_FRAME,
    RFC_FLUSH,
    RFC_FLUSHED
  } rfc_state_e;

endpackage : rfc_pkg

/* File: hdl/rfc_rx_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - setting flush clears queue memory and resets all queue pointers.
// - udp check enabled drops udp frames with a bad checksum.
// - tcp check enabled drops tcp frames with a bad checksum.
// - ip check enabled drops ip frames with a bad header checksum.
// - unicast filter enable accepts unicast frames passing the address filter.
// - pause honour in full duplex holds transmit until pause timer ends.
// - crc keep stores crc error frames; otherwise they are dropped.
// - multicast filter enable accepts multicast frames passing the filter.
// - broadcast accept takes every broadcast frame.
// - all multicast accept takes every multicast frame, broadcast included.
// - own unicast accept takes frames addressed to the station address.
// - promiscuous accept takes every frame regardless of destination.
// - inverse filter reverses the sense of the address match.
// - run enable starts reception; clearing stops after the current frame.
module rfc_rx_ctrl
  import rfc_pkg::*;
#(
  parameter int AW          = 12,
  parameter int QUANTUM_CYC = RFC_QUANTUM_CYC
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [47:0] STATION_MAC,
  input  wire logic        FULL_DUPLEX,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_SOF,
  input  wire logic        RX_EOF,
  input  wire logic        RX_CRC_ERR,
  input  wire logic        RX_IS_IP,
  input  wire logic        RX_IP_CSUM_BAD,
  input  wire logic        RX_IS_TCP,
  input  wire logic        RX_TCP_CSUM_BAD,
  input  wire logic        RX_IS_UDP,
  input  wire logic        RX_UDP_CSUM_BAD,
  input  wire logic        RX_FILTER_HIT,
  input  wire logic        RX_IS_PAUSE,
  input  wire logic [15:0] RX_PAUSE_QUANTA,
  output logic             TX_PAUSE_HOLD,
  output logic             FRAME_DONE,
  output logic             FRAME_ACCEPT,
  input  wire logic        RXQ_RD_EN,
  output logic      [7:0]  RXQ_RD_DATA,
  output logic             RXQ_RD_VALID,
  output logic             RXQ_EMPTY
);

  localparam int QW = (QUANTUM_CYC > 1) ? $clog2(QUANTUM_CYC) : 1;
  localparam logic [QW-1:0] Q_LAST  = QW'(QUANTUM_CYC - 1);
  localparam logic [AW:0]   DEPTH   = {1'b1, {AW{1'b0}}};
  localparam logic [AW-1:0] CLR_END = {AW{1'b1}};

  typedef struct packed {
    logic [15:0] ctrl;
    logic        ack;
    logic [31:0] rdata;
    rfc_state_e  st;
    logic        run;
    logic [47:0] da;
    logic [2:0]  da_cnt;
    logic        ovf;
    logic [AW:0] wr;
    logic [AW:0] cm;
    logic [AW:0] rd;
    logic [AW-1:0] clr;
    logic        rd_v;
    logic [15:0] pq;
    logic [QW-1:0] pc;
    logic        done;
    logic        acc;
    logic [15:0] n_acc;
    logic [15:0] n_drop;
  } rfc_state_s;

  rfc_state_s q_ff;
  rfc_state_s nxt_q;

  logic          req;
  logic          beat;
  logic          first;
  logic          eof;
  logic [47:0]   da_n;
  logic          full;
  logic          ovf_n;
  logic          is_bc;
  logic          is_mc;
  logic          own;
  logic          hit_u;
  logic          hit_f;
  logic          addr_ok;
  logic          csum_drop;
  logic          crc_drop;
  logic          accept;
  logic          pause_on;
  logic          pause_load;
  logic          empty;
  logic          rd_go;
  logic          mem_we;
  logic [AW-1:0] mem_waddr;
  logic [7:0]    mem_wdata;
  logic [AW:0]   wr_inc;
  logic [15:0]   c;

  assign c     = q_ff.ctrl;
  assign req   = AVS_READ | AVS_WRITE;
  assign empty = (q_ff.rd == q_ff.cm);
  assign full  = ((q_ff.wr - q_ff.rd) == DEPTH);
  // a frame starts only while running and at a start-of-frame beat
  assign first = (q_ff.st == RFC_IDLE) & RX_SOF & q_ff.run;
  assign beat  = RX_VALID & (first | (q_ff.st == RFC_FRAME));
  assign eof   = beat & RX_EOF;
  assign ovf_n = full | (q_ff.ovf & ~first);
  assign wr_inc = q_ff.wr + {{AW{1'b0}}, 1'b1};

  always_comb begin
    if (first) begin
      da_n = {40'h00_0000_0000, RX_DATA};
    end else if (q_ff.da_cnt < RFC_DA_BYTES) begin
      da_n = {q_ff.da[39:0], RX_DATA};
    end else begin
      da_n = q_ff.da;
    end
  end

  // destination classification and combined accept decision
  assign is_bc = (da_n == RFC_BCAST_DA);
  assign is_mc = da_n[RFC_MCAST_BIT];
  assign own   = (da_n == STATION_MAC);
  assign hit_u = own ^ c[RFC_B_INV];
  assign hit_f = RX_FILTER_HIT ^ c[RFC_B_INV];
  always_comb begin
    if (c[RFC_B_PROM]) begin
      addr_ok = 1'b1;
    end else if (is_bc) begin
      addr_ok = c[RFC_B_BCAST] | c[RFC_B_MCAST];
    end else if (is_mc) begin
      addr_ok = c[RFC_B_MCAST] | (c[RFC_B_MFILT] & hit_f);
    end else begin
      addr_ok = (c[RFC_B_UCAST] & hit_u)
              | (c[RFC_B_UFILT] & hit_f);
    end
  end

  assign csum_drop = (c[RFC_B_UDP] & RX_IS_UDP & RX_UDP_CSUM_BAD)
                   | (c[RFC_B_TCP] & RX_IS_TCP & RX_TCP_CSUM_BAD)
                   | (c[RFC_B_IP]  & RX_IS_IP  & RX_IP_CSUM_BAD);
  assign crc_drop  = RX_CRC_ERR & ~c[RFC_B_CRCKEEP];
  assign accept    = eof & ~ovf_n & addr_ok & ~csum_drop & ~crc_drop;

  assign pause_on   = c[RFC_B_PAUSE] & FULL_DUPLEX;
  assign pause_load = eof & RX_IS_PAUSE & ~RX_CRC_ERR & pause_on;

  assign rd_go = RXQ_RD_EN & ~empty
               & (q_ff.st != RFC_FLUSH) & (q_ff.st != RFC_FLUSHED);

  // flush sweep writes zeros, frame beats write data
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = q_ff.wr[AW-1:0];
    mem_wdata = RX_DATA;
    if (q_ff.st == RFC_FLUSH) begin
      mem_we    = 1'b1;
      mem_waddr = q_ff.clr;
      mem_wdata = 8'h00;
    end else if (beat & ~ovf_n) begin
      mem_we = 1'b1;
    end
  end

  always_comb begin
    nxt_q      = q_ff;
    nxt_q.done = 1'b0;
    nxt_q.acc  = 1'b0;
    nxt_q.rd_v = rd_go;
    nxt_q.ack  = req & ~q_ff.ack;

    // bus: read data captured on the same edge that drops waitrequest
    if (AVS_READ & ~q_ff.ack) begin
      case (AVS_ADDRESS)
        RFC_CTRL_OFS: nxt_q.rdata = {16'h0000, q_ff.ctrl};
        RFC_STAT_OFS: begin
          nxt_q.rdata                = 32'h0000_0000;
          nxt_q.rdata[RFC_S_RUN]     = q_ff.run;
          nxt_q.rdata[RFC_S_BUSY]    = (q_ff.st == RFC_FRAME);
          nxt_q.rdata[RFC_S_FLUSHED] = (q_ff.st == RFC_FLUSHED);
          nxt_q.rdata[RFC_S_PAUSED]  = (q_ff.pq != 16'h0000);
        end
        RFC_CNT_OFS:  nxt_q.rdata = {q_ff.n_drop, q_ff.n_acc};
        default:      nxt_q.rdata = 32'h0000_0000;
      endcase
    end
    if (AVS_WRITE & q_ff.ack & (AVS_ADDRESS == RFC_CTRL_OFS)) begin
      if (AVS_BYTEENABLE[0]) begin
        nxt_q.ctrl[7:0] = AVS_WRITEDATA[7:0];
      end
      if (AVS_BYTEENABLE[1]) begin
        nxt_q.ctrl[15:8] = AVS_WRITEDATA[15:8];
      end
    end

    // running state held to the end of a frame in progress
    if (c[RFC_B_RUN]) begin
      nxt_q.run = 1'b1;
    end else if ((q_ff.st != RFC_FRAME) | eof) begin
      nxt_q.run = 1'b0;
    end

    if (rd_go) begin
      nxt_q.rd = q_ff.rd + {{AW{1'b0}}, 1'b1};
    end

    case (q_ff.st)
      RFC_IDLE, RFC_FRAME: begin
        if (beat) begin
          nxt_q.da     = da_n;
          nxt_q.ovf    = ovf_n;
          nxt_q.da_cnt = first ? 3'h1 :
                         (q_ff.da_cnt < RFC_DA_BYTES) ?
                         3'(q_ff.da_cnt + 3'h1) : q_ff.da_cnt;
          nxt_q.st     = RFC_FRAME;
          if (~ovf_n) begin
            nxt_q.wr = wr_inc;
          end
        end
        if (eof) begin
          nxt_q.st   = RFC_IDLE;
          nxt_q.done = 1'b1;
          nxt_q.acc  = accept;
          if (accept) begin
            nxt_q.cm    = wr_inc;
            nxt_q.n_acc = 16'(q_ff.n_acc + 16'h0001);
          end else begin
            nxt_q.wr     = q_ff.cm;
            nxt_q.n_drop = 16'(q_ff.n_drop + 16'h0001);
          end
        end
        // flush aborts any frame; software is to stop first
        if (c[RFC_B_FLUSH]) begin
          nxt_q.st  = RFC_FLUSH;
          nxt_q.clr = {AW{1'b0}};
          nxt_q.wr  = {(AW+1){1'b0}};
          nxt_q.cm  = {(AW+1){1'b0}};
          nxt_q.rd  = {(AW+1){1'b0}};
          nxt_q.rd_v = 1'b0;
          nxt_q.done = 1'b0;
          nxt_q.acc  = 1'b0;
        end
      end
      RFC_FLUSH: begin
        nxt_q.clr = AW'(q_ff.clr + 1'b1);
        if (q_ff.clr == CLR_END) begin
          nxt_q.st = RFC_FLUSHED;
        end
      end
      RFC_FLUSHED: begin
        if (~c[RFC_B_FLUSH]) begin
          nxt_q.st = RFC_IDLE;
        end
      end
      default: nxt_q.st = RFC_IDLE;
    endcase

    // pause timer counts quanta of QUANTUM_CYC cycles
    if (~pause_on) begin
      nxt_q.pq = 16'h0000;
      nxt_q.pc = {QW{1'b0}};
    end else if (pause_load) begin
      nxt_q.pq = RX_PAUSE_QUANTA;
      nxt_q.pc = {QW{1'b0}};
    end else if (q_ff.pq != 16'h0000) begin
      if (q_ff.pc == Q_LAST) begin
        nxt_q.pc = {QW{1'b0}};
        nxt_q.pq = 16'(q_ff.pq - 16'h0001);
      end else begin
        nxt_q.pc = QW'(q_ff.pc + 1'b1);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      q_ff        <= '0;
      q_ff.ctrl   <= RFC_CTRL_RST;
      q_ff.st     <= RFC_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  rfc_mem #(
    .AW (AW),
    .DW (8)
  ) u_queue (
    .CLK   (CLK),
    .WE    (mem_we),
    .WADDR (mem_waddr),
    .WDATA (mem_wdata),
    .RE    (rd_go),
    .RADDR (q_ff.rd[AW-1:0]),
    .RDATA (RXQ_RD_DATA)
  );

  assign AVS_WAITREQUEST = req & ~q_ff.ack;
  assign AVS_READDATA    = q_ff.rdata;
  assign TX_PAUSE_HOLD   = (q_ff.pq != 16'h0000);
  assign FRAME_DONE      = q_ff.done;
  assign FRAME_ACCEPT    = q_ff.acc;
  assign RXQ_RD_VALID    = q_ff.rd_v;
  assign RXQ_EMPTY       = empty;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_flush_ptrs: assert property (q_ff.st == RFC_FLUSH |->
    q_ff.wr == '0 && q_ff.cm == '0 && q_ff.rd == '0)
    else $error("flush left queue pointers set");
  a_flush_zero: assert property (q_ff.st == RFC_FLUSH |->
    mem_we && mem_wdata == 8'h00 && mem_waddr == q_ff.clr)
    else $error("flush sweep not writing zero");
  a_udp_drop: assert property (eof && c[RFC_B_UDP] && RX_IS_UDP &&
    RX_UDP_CSUM_BAD |=> FRAME_DONE && !FRAME_ACCEPT)
    else $error("bad udp frame kept");
  a_tcp_drop: assert property (eof && c[RFC_B_TCP] && RX_IS_TCP &&
    RX_TCP_CSUM_BAD |=> FRAME_DONE && !FRAME_ACCEPT)
    else $error("bad tcp frame kept");
  a_ip_drop: assert property (eof && c[RFC_B_IP] && RX_IS_IP &&
    RX_IP_CSUM_BAD |=> FRAME_DONE && !FRAME_ACCEPT)
    else $error("bad ip frame kept");
  a_crc_drop: assert property (eof && RX_CRC_ERR &&
    !c[RFC_B_CRCKEEP] |=> !FRAME_ACCEPT)
    else $error("crc error frame kept");
  a_prom_take: assert property (eof && c[RFC_B_PROM] && !ovf_n &&
    !csum_drop && !crc_drop |=> FRAME_DONE && FRAME_ACCEPT)
    else $error("promiscuous frame dropped");
  a_bcast_take: assert property (eof && is_bc && c[RFC_B_BCAST] &&
    !ovf_n && !csum_drop && !crc_drop |=> FRAME_ACCEPT)
    else $error("broadcast frame dropped");
  a_pause_hold: assert property (pause_load &&
    RX_PAUSE_QUANTA != 16'h0000 |=> TX_PAUSE_HOLD [*2])
    else $error("pause not held");
  a_pause_off: assert property (!pause_on |=> !TX_PAUSE_HOLD)
    else $error("pause held without flow control");
  a_stop_frame: assert property (q_ff.st == RFC_FRAME && q_ff.run &&
    !eof |=> q_ff.run)
    else $error("reception stopped mid frame");
  a_ctrl_write: assert property (AVS_WRITE && !AVS_WAITREQUEST &&
    AVS_ADDRESS == RFC_CTRL_OFS && AVS_BYTEENABLE[1:0] == 2'h3
    |=> q_ff.ctrl == $past(AVS_WRITEDATA[15:0]))
    else $error("control write lost");

  c_accept: cover property (FRAME_DONE && FRAME_ACCEPT);
  c_drop:   cover property (FRAME_DONE && !FRAME_ACCEPT);
  c_flush:  cover property ($rose(q_ff.st == RFC_FLUSHED));
  c_pause:  cover property ($fell(TX_PAUSE_HOLD));

endmodule : rfc_rx_ctrl

/* File: tb/rfc_link_model.sv */
`timescale 1ns/1ps
module rfc_link_model (
  input  wire logic        CLK,
  output logic             RX_VALID,
  output logic [7:0]       RX_DATA,
  output logic             RX_SOF,
  output logic             RX_EOF,
  output logic             RX_CRC_ERR,
  output logic             RX_IS_IP,
  output logic             RX_IP_CSUM_BAD,
  output logic             RX_IS_TCP,
  output logic             RX_TCP_CSUM_BAD,
  output logic             RX_IS_UDP,
  output logic             RX_UDP_CSUM_BAD,
  output logic             RX_FILTER_HIT,
  output logic             RX_IS_PAUSE,
  output logic [15:0]      RX_PAUSE_QUANTA
);
  // one idle cycle before every beat when set
  logic slow = 1'b0;

  initial begin
    RX_VALID = 1'b0;
    RX_DATA = 8'h5a;
    RX_SOF = 1'b0;
    RX_EOF = 1'b0;
    {RX_IS_PAUSE, RX_CRC_ERR, RX_IS_IP, RX_IP_CSUM_BAD, RX_IS_TCP,
     RX_TCP_CSUM_BAD, RX_IS_UDP, RX_UDP_CSUM_BAD, RX_FILTER_HIT} = 9'h1aa;
    RX_PAUSE_QUANTA = 16'ha5a5;
  end

  // attributes are junk except on the last beat
  task automatic send(input logic [47:0] da, input logic [7:0] at,
                      input logic [15:0] pq, input int len);
    for (int i = 0; i < len; i++) begin
      if (slow) begin
        @(posedge CLK);
        RX_VALID <= 1'b0;
        RX_DATA  <= ~RX_DATA;
      end
      @(posedge CLK);
      RX_VALID <= 1'b1;
      RX_SOF   <= (i == 0);
      RX_EOF   <= (i == len - 1);
      RX_DATA  <= (i < 6) ? da[47 - 8 * i -: 8] : 8'(i);
      {RX_IS_PAUSE, RX_CRC_ERR, RX_IS_IP, RX_IP_CSUM_BAD, RX_IS_TCP,
       RX_TCP_CSUM_BAD, RX_IS_UDP, RX_UDP_CSUM_BAD, RX_FILTER_HIT}
        <= (i == len - 1) ? {pq != 16'h0, at} : ~{pq != 16'h0, at};
      RX_PAUSE_QUANTA <= (i == len - 1) ? pq : ~pq;
    end
    @(posedge CLK);
    RX_VALID <= 1'b0;
    RX_SOF   <= 1'b0;
    RX_EOF   <= 1'b0;
    RX_DATA  <= ~RX_DATA;
  endtask : send
endmodule : rfc_link_model

/* File: tb/rfc_rx_ctrl_tb.sv */
`timescale 1ns/1ps
module rfc_rx_ctrl_tb;
  import rfc_pkg::*;
  localparam int          AW  = 4;
  localparam int          QC  = 4;
  localparam logic [47:0] MAC = 48'h0211_2233_4455;
  localparam logic [47:0] OTH = 48'h0211_2233_4466;
  localparam logic [47:0] MC  = 48'h0100_5e00_0001;
  localparam logic [47:0] BC  = RFC_BCAST_DA;
  localparam logic [7:0]  CRC = 8'h80;
  localparam logic [7:0]  IPB = 8'h60;
  localparam logic [7:0]  IPG = 8'h40;
  localparam logic [7:0]  TCB = 8'h18;
  localparam logic [7:0]  UDB = 8'h06;
  localparam logic [7:0]  HIT = 8'h01;

  logic        CLK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic        FULL_DUPLEX, RX_VALID, RX_SOF, RX_EOF, RX_CRC_ERR, RX_IS_IP;
  logic        RX_IP_CSUM_BAD, RX_IS_TCP, RX_TCP_CSUM_BAD, RX_IS_UDP;
  logic        RX_UDP_CSUM_BAD, RX_FILTER_HIT, RX_IS_PAUSE, TX_PAUSE_HOLD;
  logic        FRAME_DONE, FRAME_ACCEPT, RXQ_RD_EN, RXQ_RD_VALID, RXQ_EMPTY;
  logic [7:0]  AVS_ADDRESS, RX_DATA, RXQ_RD_DATA;
  logic [15:0] RX_PAUSE_QUANTA;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd_q;
  int          err_total, n_tests;

  rfc_rx_ctrl #(
    .AW          (AW),
    .QUANTUM_CYC (QC)
  ) DUT (
    .CLK             (CLK),
    .SYS_RST         (SYS_RST),
    .AVS_ADDRESS     (AVS_ADDRESS),
    .AVS_READ        (AVS_READ),
    .AVS_WRITE       (AVS_WRITE),
    .AVS_WRITEDATA   (AVS_WRITEDATA),
    .AVS_BYTEENABLE  (4'hf),
    .AVS_READDATA    (AVS_READDATA),
    .AVS_WAITREQUEST (AVS_WAITREQUEST),
    .STATION_MAC     (MAC),
    .FULL_DUPLEX     (FULL_DUPLEX),
    .RX_VALID        (RX_VALID),
    .RX_DATA         (RX_DATA),
    .RX_SOF          (RX_SOF),
    .RX_EOF          (RX_EOF),
    .RX_CRC_ERR      (RX_CRC_ERR),
    .RX_IS_IP        (RX_IS_IP),
    .RX_IP_CSUM_BAD  (RX_IP_CSUM_BAD),
    .RX_IS_TCP       (RX_IS_TCP),
    .RX_TCP_CSUM_BAD (RX_TCP_CSUM_BAD),
    .RX_IS_UDP       (RX_IS_UDP),
    .RX_UDP_CSUM_BAD (RX_UDP_CSUM_BAD),
    .RX_FILTER_HIT   (RX_FILTER_HIT),
    .RX_IS_PAUSE     (RX_IS_PAUSE),
    .RX_PAUSE_QUANTA (RX_PAUSE_QUANTA),
    .TX_PAUSE_HOLD   (TX_PAUSE_HOLD),
    .FRAME_DONE      (FRAME_DONE),
    .FRAME_ACCEPT    (FRAME_ACCEPT),
    .RXQ_RD_EN       (RXQ_RD_EN),
    .RXQ_RD_DATA     (RXQ_RD_DATA),
    .RXQ_RD_VALID    (RXQ_RD_VALID),
    .RXQ_EMPTY       (RXQ_EMPTY)
  );

  rfc_link_model lnk (
    .CLK             (CLK),
    .RX_VALID        (RX_VALID),
    .RX_DATA         (RX_DATA),
    .RX_SOF          (RX_SOF),
    .RX_EOF          (RX_EOF),
    .RX_CRC_ERR      (RX_CRC_ERR),
    .RX_IS_IP        (RX_IS_IP),
    .RX_IP_CSUM_BAD  (RX_IP_CSUM_BAD),
    .RX_IS_TCP       (RX_IS_TCP),
    .RX_TCP_CSUM_BAD (RX_TCP_CSUM_BAD),
    .RX_IS_UDP       (RX_IS_UDP),
    .RX_UDP_CSUM_BAD (RX_UDP_CSUM_BAD),
    .RX_FILTER_HIT   (RX_FILTER_HIT),
    .RX_IS_PAUSE     (RX_IS_PAUSE),
    .RX_PAUSE_QUANTA (RX_PAUSE_QUANTA)
  );

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic avs(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= wr;
    AVS_READ      <= ~wr;
    AVS_WRITEDATA <= d;
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    if (n >= 50) chk("bus answer", 32'h0, 32'h1);
    rd_q = AVS_READDATA;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge CLK);
  endtask : avs

  // {done seen, accept} over a short window after frame end
  task automatic done_chk(input logic [1:0] exp);
    logic [1:0] got;
    got = 2'b00;
    repeat (6) begin
      @(posedge CLK);
      if (FRAME_DONE === 1'b1) got = {1'b1, FRAME_ACCEPT};
    end
    chk("frame done/accept", 32'(exp), 32'(got));
  endtask : done_chk

  task automatic flt(input logic [15:0] c, input logic [47:0] da,
                     input logic [7:0] at, input logic [1:0] exp);
    avs(1'b1, RFC_CTRL_OFS, {16'h0, c});
    lnk.send(da, at, 16'h0, 8);
    done_chk(exp);
  endtask : flt

  task automatic t_regs;
    avs(1'b0, RFC_CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h0, rd_q);
    avs(1'b1, RFC_CTRL_OFS, 32'hffff_7ffe);
    avs(1'b0, RFC_CTRL_OFS, 32'h0);
    chk("ctrl rw", 32'h0000_7ffe, rd_q);
    avs(1'b1, RFC_CTRL_OFS, 32'h0);
    avs(1'b0, 8'h10, 32'h0);
    chk("unmapped read", 32'h0, rd_q);
  endtask : t_regs

  task automatic t_filter;
    flt(16'h0081, BC, 8'h00, 2'b11);
    flt(16'h0001, BC, 8'h00, 2'b10);
    flt(16'h0041, BC, 8'h00, 2'b11);
    flt(16'h0041, MC, 8'h00, 2'b11);
    flt(16'h0101, MC, HIT, 2'b11);
    flt(16'h0101, MC, 8'h00, 2'b10);
    flt(16'h0021, MAC, 8'h00, 2'b11);
    flt(16'h0021, OTH, 8'h00, 2'b10);
    flt(16'h0023, OTH, 8'h00, 2'b11);
    flt(16'h0801, OTH, HIT, 2'b11);
    flt(16'h0803, OTH, HIT, 2'b10);
    flt(16'h0011, OTH, 8'h00, 2'b11);
    flt(16'h0011, OTH, CRC, 2'b10);
    flt(16'h0211, OTH, CRC, 2'b11);
    flt(16'h4011, OTH, UDB, 2'b10);
    flt(16'h0011, OTH, UDB, 2'b11);
    flt(16'h2011, OTH, TCB, 2'b10);
    flt(16'h1011, OTH, IPB, 2'b10);
    flt(16'h1011, OTH, IPG, 2'b11);
  endtask : t_filter

  task automatic t_run;
    avs(1'b1, RFC_CTRL_OFS, 32'h0091);
    lnk.slow = 1'b1;
    fork
      lnk.send(BC, 8'h00, 16'h0, 12);
      begin
        repeat (6) @(posedge CLK);
        avs(1'b1, RFC_CTRL_OFS, 32'h0090);
      end
    join
    lnk.slow = 1'b0;
    done_chk(2'b11);
    lnk.send(BC, 8'h00, 16'h0, 8);
    done_chk(2'b00);
  endtask : t_run

  task automatic t_pause;
    avs(1'b1, RFC_CTRL_OFS, 32'h0411);
    lnk.send(MC, 8'h00, 16'h0002, 8);
    @(posedge CLK);
    chk("pause hold start", 32'h1, 32'(TX_PAUSE_HOLD));
    avs(1'b0, RFC_STAT_OFS, 32'h0);
    chk("status run pause", 32'h9, rd_q);
    repeat (4) @(posedge CLK);
    chk("pause hold last", 32'h1, 32'(TX_PAUSE_HOLD));
    @(posedge CLK);
    chk("pause hold end", 32'h0, 32'(TX_PAUSE_HOLD));
    lnk.send(MC, 8'h00, 16'h0002, 8);
    @(posedge CLK);
    chk("pause reload", 32'h1, 32'(TX_PAUSE_HOLD));
    FULL_DUPLEX <= 1'b0;
    repeat (2) @(posedge CLK);
    chk("pause half duplex", 32'h0, 32'(TX_PAUSE_HOLD));
    avs(1'b1, RFC_CTRL_OFS, 32'h0011);
    FULL_DUPLEX <= 1'b1;
    lnk.send(MC, 8'h00, 16'h0002, 8);
    @(posedge CLK);
    chk("pause ignored", 32'h0, 32'(TX_PAUSE_HOLD));
  endtask : t_pause

  task automatic t_flush;
    logic [31:0] cnt;
    repeat (10) @(posedge CLK);
    chk("queue drained", 32'h1, 32'(RXQ_EMPTY));
    RXQ_RD_EN <= 1'b0;
    flt(16'h0081, BC, 8'h00, 2'b11);
    chk("queue filled", 32'h0, 32'(RXQ_EMPTY));
    RXQ_RD_EN <= 1'b1;
    @(posedge CLK);
    RXQ_RD_EN <= 1'b0;
    @(posedge CLK);
    chk("queue head", 32'h1ff, 32'({RXQ_RD_VALID, RXQ_RD_DATA}));
    // seven bytes left, room for nine: a ten byte frame must be dropped
    avs(1'b0, RFC_CNT_OFS, 32'h0);
    cnt = rd_q;
    lnk.send(BC, 8'h00, 16'h0, 10);
    done_chk(2'b10);
    avs(1'b0, RFC_CNT_OFS, 32'h0);
    chk("overflow counts", cnt + 32'h0001_0000, rd_q);
    avs(1'b1, RFC_CTRL_OFS, 32'h0080);
    avs(1'b1, RFC_CTRL_OFS, 32'h8080);
    repeat (20) @(posedge CLK);
    chk("queue flushed", 32'h1, 32'(RXQ_EMPTY));
    avs(1'b0, RFC_STAT_OFS, 32'h0);
    chk("flush done", 32'h1, 32'(rd_q[RFC_S_FLUSHED]));
    RXQ_RD_EN <= 1'b1;
    flt(16'h0081, BC, 8'h00, 2'b11);
  endtask : t_flush

  initial begin
    SYS_RST = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 8'h00;
    AVS_WRITEDATA = 32'h0;
    FULL_DUPLEX = 1'b1;
    RXQ_RD_EN = 1'b1;
    err_total = 0;
    n_tests = 0;
    repeat (10) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_filter();
    t_run();
    t_pause();
    t_flush();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    print_verdict();
  end
endmodule : rfc_rx_ctrl_tb
